/* File: fgr_pkg.sv */
// fine granularity refresh: shared constants, command and bus carriers
// assumes a 20 MHz core clock; the command bus is sampled on that clock
package fgr_pkg;

	// clock and timing
	localparam int CLK_PERIOD_PS  = 50000;
	localparam int REFI_BASE_NS   = 7800;
	localparam int TRFC1_NS       = 260;
	localparam int TRFC2_NS       = 160;
	localparam int TRFC4_NS       = 110;
	localparam int TIME_W         = 16;
	// least times round up, longest times round down
	localparam logic [TIME_W-1:0] TRFC1_CYC = TIME_W'((TRFC1_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS);
	localparam logic [TIME_W-1:0] TRFC2_CYC = TIME_W'((TRFC2_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS);
	localparam logic [TIME_W-1:0] TRFC4_CYC = TIME_W'((TRFC4_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS);
	localparam logic [TIME_W-1:0] REFI1_CYC = TIME_W'((REFI_BASE_NS * 1000) / CLK_PERIOD_PS);
	localparam logic [TIME_W-1:0] REFI2_CYC = TIME_W'((REFI_BASE_NS * 1000 / 2) / CLK_PERIOD_PS);
	localparam logic [TIME_W-1:0] REFI4_CYC = TIME_W'((REFI_BASE_NS * 1000 / 4) / CLK_PERIOD_PS);

	// refresh mode field of the refresh_mode_register
	localparam int         MODE_LSB      = 6;
	localparam int         MODE_MSB      = 8;
	localparam int         MODE_OTF_BIT  = 2;
	localparam logic [2:0] MODE_FIXED_1X = 3'h0;
	localparam logic [2:0] MODE_FIXED_2X = 3'h1;
	localparam logic [2:0] MODE_FIXED_4X = 3'h2;
	localparam logic [2:0] MODE_OTF_2X   = 3'h5;
	localparam logic [2:0] MODE_OTF_4X   = 3'h6;
	localparam logic [2:0] MODE_RESET    = MODE_FIXED_1X;

	// mode_register_write target: bank group 0, bank 3
	localparam logic [1:0] MR_REFRESH_BANK = 2'h3;

	typedef enum logic [1:0] {
		RATE_1X = 2'b00,
		RATE_2X = 2'b01,
		RATE_4X = 2'b10
	} rate_type;

	// command bus as sampled at the clock edge
	typedef struct packed {
		logic        cs_n;
		logic        activate_n;
		logic        row_strobe_n;
		logic        column_strobe_n;
		logic        write_enable_n;
		logic        rate_select_bit;
		logic [1:0]  bank_addr;
		logic [13:0] addr;
	} cmd_bus_type;

	// wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_type;

	// register map
	localparam logic [7:0] REG_MODE   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FLAGS  = 8'h08;
	localparam logic [7:0] REG_COUNT  = 8'h0c;

	// status fields
	localparam int ST_BUSY      = 0;
	localparam int ST_RATE_LSB  = 1;
	localparam int ST_SUB_LSB   = 4;

	// sticky flag bits, write one to clear
	localparam int FLAGS_W        = 6;
	localparam int FL_ODD_CHANGE  = 0;
	localparam int FL_ODD_BETWEEN = 1;
	localparam int FL_RESERVED    = 2;
	localparam int FL_EARLY       = 3;
	localparam int FL_LATE        = 4;
	localparam int FL_ODD_AT_REF  = 5;

endpackage

/* File: refresh_cycle_timer.sv */
// refresh cycle timer: busy from a refresh command until its cycle time ends
// assumes load is a one-cycle pulse with the count of the command's rate
`timescale 1ns/1ps
module refresh_cycle_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// load from a refresh command
	input  wire logic         load,
	input  wire logic [W-1:0] load_count,
	// busy while the cycle time runs
	output logic              busy
);
	import fgr_pkg::*;

	typedef enum logic [0:0] {
		PH_IDLE = 1'b0,
		PH_RUN  = 1'b1
	} phase_type;

	typedef struct packed {
		phase_type    phase;
		logic [W-1:0] count;
	} timer_type;

	timer_type cur;
	timer_type next_cur;

	always_comb begin
		next_cur = cur;
		case (cur.phase)
			PH_IDLE: begin
				if (load) begin
					next_cur.phase = PH_RUN;
					next_cur.count = load_count - W'(1);
				end
			end
			PH_RUN: begin
				// a new command restarts with its own rate's time
				if (load) begin
					next_cur.count = load_count - W'(1);
				end else if (cur.count == '0) begin
					next_cur.phase = PH_IDLE;
				end else begin
					next_cur.count = cur.count - W'(1);
				end
			end
			default: begin
				next_cur.phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur <= '{phase: PH_IDLE, count: '0};
		end else if (ce) begin
			cur <= next_cur;
		end
	end

	assign busy = (cur.phase == PH_RUN);

endmodule

/* File: fine_granularity_refresh.sv */
// fine granularity refresh: mode field, per-command rate, timing and count checks
// assumes the command bus is synchronous to MCLK and sampled once per edge
`timescale 1ns/1ps
module fine_granularity_refresh (
	// clock, reset, enable
	input  wire logic                MCLK,
	input  wire logic                RST_N,
	input  wire logic                CE,
	// command bus
	input  wire fgr_pkg::cmd_bus_type CMD,
	// wishbone slave
	input  wire fgr_pkg::wb_req_type WB_REQ,
	output logic [31:0]              WB_DAT_O,
	output logic                     WB_ACK,
	// refresh engine
	output logic                     REFRESH_START,
	output fgr_pkg::rate_type        REFRESH_RATE,
	output logic                     REFRESH_BUSY
);
	import fgr_pkg::*;

	typedef struct packed {
		logic [2:0]         mode;
		logic [1:0]         sub_count;
		rate_type           rate;
		logic [FLAGS_W-1:0] flags;
		logic [15:0]        refresh_count;
		logic [TIME_W-1:0]  interval_left;
		logic               interval_armed;
		logic               start;
		logic               ack;
		logic [31:0]        rdata;
	} state_type;

	state_type cur;
	state_type next_cur;
	logic      busy;
	logic      is_refresh;
	logic      is_mode_write;
	logic      wb_access;

	function automatic logic reserved_code(input logic [2:0] code);
		reserved_code = !(code == MODE_FIXED_1X || code == MODE_FIXED_2X ||
			code == MODE_FIXED_4X || code == MODE_OTF_2X || code == MODE_OTF_4X);
	endfunction

	// sub-rate the mode runs at, fixed or on-the-fly alike
	function automatic rate_type mode_class(input logic [2:0] code);
		case (code[1:0])
			2'b01:   mode_class = RATE_2X;
			2'b10:   mode_class = RATE_4X;
			default: mode_class = RATE_1X;
		endcase
	endfunction

	function automatic rate_type command_rate(input logic [2:0] code, input logic sel);
		if (code[MODE_OTF_BIT] && !sel) begin
			command_rate = RATE_1X;
		end else begin
			command_rate = mode_class(code);
		end
	endfunction

	// sub-rate count not at a whole normal interval
	function automatic logic count_open(input rate_type r, input logic [1:0] n);
		case (r)
			RATE_2X: count_open = n[0];
			RATE_4X: count_open = (n != 2'h0);
			default: count_open = 1'b0;
		endcase
	endfunction

	function automatic logic [TIME_W-1:0] cycle_time(input rate_type r);
		case (r)
			RATE_2X: cycle_time = TRFC2_CYC;
			RATE_4X: cycle_time = TRFC4_CYC;
			default: cycle_time = TRFC1_CYC;
		endcase
	endfunction

	function automatic logic [TIME_W-1:0] interval_time(input rate_type r);
		case (r)
			RATE_2X: interval_time = REFI2_CYC;
			RATE_4X: interval_time = REFI4_CYC;
			default: interval_time = REFI1_CYC;
		endcase
	endfunction

	assign is_refresh = !CMD.cs_n && CMD.activate_n && !CMD.row_strobe_n &&
		!CMD.column_strobe_n && CMD.write_enable_n;
	assign is_mode_write = !CMD.cs_n && CMD.activate_n && !CMD.row_strobe_n &&
		!CMD.column_strobe_n && !CMD.write_enable_n && !CMD.rate_select_bit &&
		(CMD.bank_addr == MR_REFRESH_BANK);
	assign wb_access = WB_REQ.cyc && WB_REQ.stb;

	always_comb begin
		logic [FLAGS_W-1:0] set_flags;
		logic [FLAGS_W-1:0] clr_flags;
		logic [2:0]         new_mode;
		logic               mode_req;
		rate_type           r;

		set_flags = '0;
		clr_flags = '0;
		new_mode  = cur.mode;
		mode_req  = 1'b0;
		r         = command_rate(cur.mode, CMD.rate_select_bit);
		next_cur  = cur;
		next_cur.start = 1'b0;

		// refresh command
		if (is_refresh) begin
			next_cur.start         = 1'b1;
			next_cur.rate          = r;
			next_cur.refresh_count = cur.refresh_count + 16'h1;
			if (busy) begin
				set_flags[FL_EARLY] = 1'b1;
			end
			// interval of the new rate counts from this command
			next_cur.interval_left  = interval_time(r);
			next_cur.interval_armed = 1'b1;
			if (r == RATE_1X) begin
				if (count_open(mode_class(cur.mode), cur.sub_count)) begin
					set_flags[FL_ODD_BETWEEN] = 1'b1;
				end
				next_cur.sub_count = 2'h0;
			end else if (mode_class(cur.mode) == RATE_2X) begin
				// double rate counts modulo two
				next_cur.sub_count = {1'b0, ~cur.sub_count[0]};
			end else begin
				next_cur.sub_count = cur.sub_count + 2'h1;
			end
		end else if (cur.interval_armed) begin
			if (cur.interval_left == '0) begin
				set_flags[FL_LATE]      = 1'b1;
				next_cur.interval_armed = 1'b0;
			end else begin
				next_cur.interval_left = cur.interval_left - TIME_W'(1);
			end
		end

		// mode change from the command bus or from software
		if (is_mode_write) begin
			new_mode = CMD.addr[MODE_MSB:MODE_LSB];
			mode_req = 1'b1;
		end else if (wb_access && WB_REQ.we && cur.ack && WB_REQ.adr == REG_MODE &&
				WB_REQ.sel[1]) begin
			new_mode = WB_REQ.dat[MODE_MSB:MODE_LSB];
			mode_req = 1'b1;
		end
		if (mode_req) begin
			if (reserved_code(new_mode)) begin
				set_flags[FL_RESERVED] = 1'b1;
			end else begin
				next_cur.mode = new_mode;
				// same sub-rate, fixed or on-the-fly, is no rate change
				if (mode_class(new_mode) != mode_class(cur.mode)) begin
					if (count_open(mode_class(cur.mode), cur.sub_count)) begin
						set_flags[FL_ODD_CHANGE] = 1'b1;
					end
					next_cur.sub_count = 2'h0;
				end
			end
		end

		// register access: one wait state, ack drops after one cycle
		next_cur.ack = wb_access && !cur.ack;
		if (wb_access && !cur.ack) begin
			case (WB_REQ.adr)
				REG_MODE: begin
					next_cur.rdata = 32'h0;
					next_cur.rdata[MODE_MSB:MODE_LSB] = cur.mode;
				end
				REG_STATUS: begin
					next_cur.rdata = 32'h0;
					next_cur.rdata[ST_BUSY] = busy;
					next_cur.rdata[ST_RATE_LSB +: 2] = cur.rate;
					next_cur.rdata[ST_SUB_LSB +: 2] = cur.sub_count;
				end
				REG_FLAGS: begin
					next_cur.rdata = 32'(cur.flags);
				end
				REG_COUNT: begin
					next_cur.rdata = 32'(cur.refresh_count);
				end
				default: begin
					next_cur.rdata = 32'h0;
				end
			endcase
		end
		if (wb_access && WB_REQ.we && cur.ack && WB_REQ.adr == REG_FLAGS && WB_REQ.sel[0]) begin
			clr_flags = WB_REQ.dat[FLAGS_W-1:0];
		end
		set_flags[FL_ODD_AT_REF] = count_open(mode_class(next_cur.mode), next_cur.sub_count)
			&& !cur.flags[FL_ODD_AT_REF] && is_refresh;
		// a flag raised in the clearing cycle stays set, except FL_ODD_AT_REF, which clears if already set
		next_cur.flags = (cur.flags & ~clr_flags) | set_flags;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			cur <= '{mode: MODE_RESET, sub_count: 2'h0, rate: RATE_1X, flags: '0,
				refresh_count: 16'h0, interval_left: '0, interval_armed: 1'b0,
				start: 1'b0, ack: 1'b0, rdata: 32'h0};
		end else if (CE) begin
			cur <= next_cur;
		end
	end

	refresh_cycle_timer #(
		.W(TIME_W)
	) u_timer (
		.clk        (MCLK),
		.rst_n      (RST_N),
		.ce         (CE),
		.load       (is_refresh),
		.load_count (cycle_time(command_rate(cur.mode, CMD.rate_select_bit))),
		.busy       (busy)
	);

	assign WB_DAT_O      = cur.rdata;
	assign WB_ACK        = cur.ack;
	assign REFRESH_START = cur.start;
	assign REFRESH_RATE  = cur.rate;
	assign REFRESH_BUSY  = busy;

endmodule

/* File: fgr_assertions.sv */
// checker for fine_granularity_refresh port timing
// assumes binding to the top module; CE gates command sampling
`timescale 1ns/1ps
module fgr_assertions (
	// clock and reset
	input wire logic                 MCLK,
	input wire logic                 RST_N,
	input wire logic                 CE,
	// buses
	input wire fgr_pkg::cmd_bus_type CMD,
	input wire fgr_pkg::wb_req_type  WB_REQ,
	input wire logic [31:0]          WB_DAT_O,
	input wire logic                 WB_ACK,
	// refresh engine
	input wire logic                 REFRESH_START,
	input wire fgr_pkg::rate_type    REFRESH_RATE,
	input wire logic                 REFRESH_BUSY
);
	import fgr_pkg::*;
	logic ref_cmd;
	assign ref_cmd = CE && !CMD.cs_n && CMD.activate_n && !CMD.row_strobe_n
		&& !CMD.column_strobe_n && CMD.write_enable_n;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// start pulse of a given rate with no refresh behind it
	sequence s_start(rate_type r);
		REFRESH_START && REFRESH_RATE == r && !ref_cmd;
	endsequence
	start_after_ref_a: assert property (ref_cmd |=> REFRESH_START)
		else $error("start missing after refresh");
	no_stray_start_a: assert property (!ref_cmd |=> !REFRESH_START)
		else $error("start without refresh");
	busy_1x_a: assert property (s_start(RATE_1X) ##1 !ref_cmd[*5]
		|-> REFRESH_BUSY ##1 !REFRESH_BUSY) else $error("busy length 1x");
	busy_2x_a: assert property (s_start(RATE_2X) ##1 !ref_cmd[*3]
		|-> REFRESH_BUSY ##1 !REFRESH_BUSY) else $error("busy length 2x");
	busy_4x_a: assert property (s_start(RATE_4X) ##1 !ref_cmd[*2]
		|-> REFRESH_BUSY ##1 !REFRESH_BUSY) else $error("busy length 4x");
	rate_hold_a: assert property ($past(RST_N) && !REFRESH_START
		|-> $stable(REFRESH_RATE)) else $error("rate moved without refresh");
	ack_after_req_a: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_ACK |=> WB_ACK)
		else $error("ack missing");
	ack_pulse_a: assert property (WB_ACK |=> !WB_ACK)
		else $error("ack held");
endmodule

bind fine_granularity_refresh fgr_assertions u_chk (.MCLK, .RST_N, .CE, .CMD, .WB_REQ,
	.WB_DAT_O, .WB_ACK, .REFRESH_START, .REFRESH_RATE, .REFRESH_BUSY);

/* File: fgr_ctrl_model.sv */
// memory controller model issuing refresh and mode writes
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module fgr_ctrl_model (
	// clock
	input  wire logic            clk,
	// command bus
	output fgr_pkg::cmd_bus_type cmd
);
	import fgr_pkg::*;
	initial cmd = {1'b1, 21'h0};
	// deselected lines toggle so no stale value stands
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			cmd <= {1'b1, ~cmd[20:0]};
		end
	endtask
	task automatic refresh(input logic rs, input int n);
		@(posedge clk);
		cmd <= {5'b01001, rs, ~cmd[15:0]};
		idle(n + 1);
	endtask
	task automatic mode_write(input logic [2:0] m);
		@(posedge clk);
		cmd <= {6'b010000, MR_REFRESH_BANK, 5'h0, m, 6'h0};
		idle(2);
	endtask
endmodule

/* File: tb.sv */
// self-checking bench for fine_granularity_refresh with an integer model
// assumes the partner model drives the command bus
`timescale 1ns/1ps
module tb;
	import fgr_pkg::*;
	logic        mclk;
	logic        rst_n;
	cmd_bus_type cmd;
	wb_req_type  wb_req;
	logic [31:0] wb_dat_o;
	logic        wb_ack;
	logic        refresh_start;
	rate_type    refresh_rate;
	logic        refresh_busy;
	logic [31:0] rd;
	int          bad_count;
	int          comparisons;
	int          seed;
	int          mode;
	int          cnt;
	int          fl;
	int          rate;
	int          modes[6] = '{1, 5, 2, 6, 0, 5};
	fine_granularity_refresh u_dut (.MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .CMD(cmd),
		.WB_REQ(wb_req), .WB_DAT_O(wb_dat_o), .WB_ACK(wb_ack), .REFRESH_START(refresh_start),
		.REFRESH_RATE(refresh_rate), .REFRESH_BUSY(refresh_busy));
	fgr_ctrl_model u_ctrl (.clk(mclk), .cmd(cmd));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		for (i = 0; i < 20; i++) begin
			@(posedge mclk);
			if (wb_ack === 1'b1)
				break;
		end
		if (i == 20) begin
			bad_count++;
			test_done();
		end
		rd = wb_dat_o;
		wb_req <= '0;
	endtask
	// sub-rate of a mode code: 1, 2 or 4
	function automatic int sub(int m);
		return (m & 2) ? 4 : ((m & 1) ? 2 : 1);
	endfunction
	task automatic set_mode(input int m, input logic by_cmd);
		if (by_cmd)
			u_ctrl.mode_write(3'(m));
		else
			wb(1'b1, REG_MODE, 32'(m) << MODE_LSB);
		if (m == 3 || m == 4 || m == 7)
			fl |= 4;
		else if (sub(m) != sub(mode)) begin
			if (cnt != 0)
				fl |= 1;
			cnt = 0;
		end
		if (m != 3 && m != 4 && m != 7)
			mode = m;
		wb(1'b0, REG_MODE, 0);
		chk("mode", mode << MODE_LSB, rd & 32'h1c0);
	endtask
	// early leaves one idle cycle, so the next refresh hits a busy cycle time
	task automatic ref_chk(input logic rs, input logic early);
		rate = (mode & 4) ? (rs ? sub(mode) : 1) : sub(mode);
		if (rate == 1) begin
			if (cnt != 0)
				fl |= 2;
			cnt = 0;
		end else
			cnt = (cnt + 1) % rate;
		if (cnt != 0)
			fl |= 32;
		u_ctrl.refresh(rs, early ? 0 : (rate == 1 ? int'(TRFC1_CYC)
			: (rate == 2 ? int'(TRFC2_CYC) : int'(TRFC4_CYC))));
		chk("rate", rate / 2, refresh_rate);
		if (!early) begin
			wb(1'b0, REG_STATUS, 0);
			chk("status", (cnt << ST_SUB_LSB) | (rate / 2 << ST_RATE_LSB), rd & 32'h37);
		end
	endtask
	initial begin
		seed = 32'h75d8;
		bad_count = 0;
		comparisons = 0;
		mode = 0;
		cnt = 0;
		fl = 0;
		rst_n = 1'b0;
		wb_req = '0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, 8'(i * 4), 0);
			chk("reset", 0, rd);
		end
		foreach (modes[i]) begin
			set_mode(modes[i], i[0]);
			repeat (3) ref_chk(1'($random(seed)), 1'b0);
		end
		ref_chk(1'b0, 1'b0);
		ref_chk(1'b1, 1'b0);
		ref_chk(1'b0, 1'b0);
		set_mode(3, 1'b0);
		ref_chk(1'b0, 1'b1);
		ref_chk(1'b0, 1'b0);
		fl |= 8;
		wb(1'b0, REG_FLAGS, 0);
		chk("flags", fl, rd & 32'h2f);
		wb(1'b1, REG_FLAGS, 32'h3f);
		wb(1'b0, REG_FLAGS, 0);
		chk("cleared", 0, rd & 32'h2f);
		test_done();
	end
endmodule
